// ===== include/pmis_defines.svh
// register offsets, field positions, reset values of the pci mailbox interrupt block
`ifndef PMIS_DEFINES_SVH
`define PMIS_DEFINES_SVH

// byte addresses on the register port
`define PMIS_OMB_BASE 7'h00
`define PMIS_IMB_BASE 7'h10
`define PMIS_MAILBOX_EMPTY_FULL_STATUS_ADDR 7'h34
`define PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR 7'h38

// control/status field positions
`define PMIS_OUT_BYTE_LSB 0
`define PMIS_OUT_MB_LSB 2
`define PMIS_OUT_EN_BIT 4
`define PMIS_IN_BYTE_LSB 8
`define PMIS_IN_MB_LSB 10
`define PMIS_IN_EN_BIT 12
`define PMIS_OUT_IRQ_BIT 16
`define PMIS_IN_IRQ_BIT 17

// empty/full status layout
`define PMIS_IN_FULL_LSB 16
`define PMIS_OUT_EMPTY_LSB 0

// reset values
`define PMIS_OUT_EMPTY_RST 16'hffff
`define PMIS_IN_FULL_RST 16'h0000
`define PMIS_CFG_RST 5'h00

`endif

// ===== include/pmis_pkg.sv
// types shared by the pci mailbox interrupt block
package pmis_pkg;
    typedef logic [1:0] pmis_mbsel_t;
    typedef logic [1:0] pmis_bytesel_t;
    typedef logic [4:0] pmis_cfg_t;
    typedef logic [15:0] pmis_flags_t;
endpackage

// ===== rtl/pmis_mailbox_irq.sv
// pci side mailboxes, byte status and mailbox interrupt request
`timescale 1ns/10ps
`include "pmis_defines.svh"

// Summary of operation
// - indicators at bits 16 and 17, readable
// - status 31:16 flags full incoming bytes
// - status 15:0 flags empty outgoing bytes
// - host read of incoming byte clears full
// - writing one clears indicator, zero keeps
// - interrupt line held while request pending
// - enabled add-on read of chosen byte raises outgoing
// - enabled add-on write of chosen byte raises incoming
module pmis_mailbox_irq
    import pmis_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // host register port
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [6:0] regAddr,
    input wire logic [3:0] regBe,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    output logic regRdValid,
    // add-on write of incoming mailboxes
    input wire logic aoWrStb,
    input wire logic [1:0] aoWrMb,
    input wire logic [3:0] aoWrBe,
    input wire logic [31:0] aoWrData,
    // add-on read of outgoing mailboxes
    input wire logic aoRdStb,
    input wire logic [1:0] aoRdMb,
    input wire logic [3:0] aoRdBe,
    output logic [31:0] aoRdData,
    // pci interrupt line
    output logic intaN
);
    logic [31:0] outMb_r [4];
    logic [31:0] inMb_r [4];
    pmis_flags_t outEmpty_r;
    pmis_flags_t inFull_r;
    pmis_cfg_t outCfg_r;
    pmis_cfg_t inCfg_r;
    logic [31:0] regRdata_r;
    logic regRdValid_r;
    logic [31:0] aoRdData_r;
    logic outIrq;
    logic inIrq;
    logic outEv;
    logic inEv;
    logic csrWr;
    logic outMbWr;
    logic inMbRd;
    pmis_mbsel_t hostMb;
    pmis_flags_t hostByteSel;
    pmis_flags_t aoWrSel;
    pmis_flags_t aoRdSel;
    logic [31:0] intcsrView;
    logic [31:0] mbefView;

    assign hostMb = regAddr[3:2];
    assign csrWr = regWr && (regAddr == `PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR);
    assign outMbWr = regWr && (regAddr[6:4] == 3'(`PMIS_OMB_BASE >> 4));
    assign inMbRd = regRd && (regAddr[6:4] == 3'(`PMIS_IMB_BASE >> 4));

    // byte enable masks over the sixteen mailbox bytes, one bit per enabled byte
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : gSel
            assign hostByteSel[g] = (hostMb == pmis_mbsel_t'(g / 4)) && regBe[g % 4];
            assign aoWrSel[g] = aoWrStb && (aoWrMb == pmis_mbsel_t'(g / 4)) && aoWrBe[g % 4];
            assign aoRdSel[g] = aoRdStb && (aoRdMb == pmis_mbsel_t'(g / 4)) && aoRdBe[g % 4];
        end
    endgenerate

    // qualifying events for the two requests
    assign outEv = outCfg_r[`PMIS_OUT_EN_BIT] && aoRdSel[outCfg_r[3:0]];
    assign inEv = inCfg_r[`PMIS_IN_EN_BIT - 8] && aoWrSel[inCfg_r[3:0]];

    pmis_sticky_flag uOutFlag (
        .clk(clk),
        .nrst(nrst),
        .setEv(outEv),
        .clrEv(csrWr && regBe[2] && regWdata[`PMIS_OUT_IRQ_BIT]),
        .flag(outIrq)
    );

    pmis_sticky_flag uInFlag (
        .clk(clk),
        .nrst(nrst),
        .setEv(inEv),
        .clrEv(csrWr && regBe[2] && regWdata[`PMIS_IN_IRQ_BIT]),
        .flag(inIrq)
    );

    assign intaN = !(outIrq || inIrq);

    // interrupt configuration fields
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            outCfg_r <= `PMIS_CFG_RST;
            inCfg_r <= `PMIS_CFG_RST;
        end else if (csrWr) begin
            if (regBe[0]) begin
                outCfg_r <= regWdata[4:0];
            end
            if (regBe[1]) begin
                inCfg_r <= regWdata[12:8];
            end
        end
    end

    // mailbox data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                outMb_r[i] <= 32'h0000_0000;
                inMb_r[i] <= 32'h0000_0000;
            end
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (outMbWr && regBe[b]) begin
                    outMb_r[hostMb][8*b +: 8] <= regWdata[8*b +: 8];
                end
                if (aoWrStb && aoWrBe[b]) begin
                    inMb_r[aoWrMb][8*b +: 8] <= aoWrData[8*b +: 8];
                end
            end
        end
    end

    // byte status; hardware set wins over the clearing access
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            outEmpty_r <= `PMIS_OUT_EMPTY_RST;
            inFull_r <= `PMIS_IN_FULL_RST;
        end else begin
            outEmpty_r <= aoRdSel | (outEmpty_r & ~(outMbWr ? hostByteSel : 16'h0000));
            inFull_r <= aoWrSel | (inFull_r & ~(inMbRd ? hostByteSel : 16'h0000));
        end
    end

    always_comb begin
        intcsrView = 32'h0000_0000;
        intcsrView[4:0] = outCfg_r;
        intcsrView[12:8] = inCfg_r;
        intcsrView[`PMIS_OUT_IRQ_BIT] = outIrq;
        intcsrView[`PMIS_IN_IRQ_BIT] = inIrq;
        mbefView = {inFull_r, outEmpty_r};
    end

    // host read data, one cycle after the read strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata_r <= 32'h0000_0000;
            regRdValid_r <= 1'b0;
        end else begin
            regRdValid_r <= regRd;
            if (regRd) begin
                if (regAddr == `PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR) begin
                    regRdata_r <= intcsrView;
                end else if (regAddr == `PMIS_MAILBOX_EMPTY_FULL_STATUS_ADDR) begin
                    regRdata_r <= mbefView;
                end else if (regAddr[6:4] == 3'(`PMIS_OMB_BASE >> 4)) begin
                    regRdata_r <= outMb_r[hostMb];
                end else if (inMbRd) begin
                    regRdata_r <= inMb_r[hostMb];
                end else begin
                    // unmapped offsets read as zero
                    regRdata_r <= 32'h0000_0000;
                end
            end
        end
    end

    // add-on read data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aoRdData_r <= 32'h0000_0000;
        end else if (aoRdStb) begin
            aoRdData_r <= outMb_r[aoRdMb];
        end
    end

    assign regRdata = regRdata_r;
    assign regRdValid = regRdValid_r;
    assign aoRdData = aoRdData_r;

    // checks
    logic outClr;
    assign outClr = csrWr && regBe[2] && regWdata[`PMIS_OUT_IRQ_BIT];

    // the line may only be released in the cycle after a write-one clear
    chk_line_release: assert property (@(posedge clk) disable iff (!nrst)
        $rose(intaN) |-> $past(csrWr && regBe[2]
        && (regWdata[`PMIS_OUT_IRQ_BIT] || regWdata[`PMIS_IN_IRQ_BIT])))
        else $error("interrupt line released without clear");
    chk_out_raise: assert property (@(posedge clk) disable iff (!nrst)
        outEv |=> outIrq && !intaN) else $error("outgoing request not raised");
    chk_in_raise: assert property (@(posedge clk) disable iff (!nrst)
        inEv |=> inIrq && !intaN) else $error("incoming request not raised");
    chk_w1c_clear: assert property (@(posedge clk) disable iff (!nrst)
        outClr && !outEv |=> !outIrq) else $error("write one did not clear");
    chk_w0_keep: assert property (@(posedge clk) disable iff (!nrst)
        inIrq && csrWr && !regWdata[`PMIS_IN_IRQ_BIT] |=> inIrq)
        else $error("write zero changed request");
    chk_irq_hold: assert property (@(posedge clk) disable iff (!nrst)
        outIrq && !outClr |=> outIrq)
        else $error("request dropped without clear");
    chk_rd_clear: assert property (@(posedge clk) disable iff (!nrst)
        inMbRd && regBe[0] && !(aoWrStb && aoWrMb == hostMb) |=> !inFull_r[{$past(hostMb), 2'b00}])
        else $error("incoming read did not clear full");
    chk_full_set: assert property (@(posedge clk) disable iff (!nrst)
        aoWrStb && aoWrBe[3] |=> mbefView[16 + 4 * $past(aoWrMb) + 3])
        else $error("full flag not reported");
    chk_empty_set: assert property (@(posedge clk) disable iff (!nrst)
        aoRdStb && aoRdBe[2] |=> outEmpty_r[{$past(aoRdMb), 2'b10}])
        else $error("empty flag not set");
    chk_csr_read: assert property (@(posedge clk) disable iff (!nrst)
        regRd && regAddr == `PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR |=> regRdValid
        && regRdata[17:16] == {$past(inIrq), $past(outIrq)}) else $error("indicator read wrong");

    cov_out_irq: cover property (@(posedge clk) disable iff (!nrst) outEv ##[1:20] outClr);
    cov_in_irq: cover property (@(posedge clk) disable iff (!nrst) inEv ##[1:20] inMbRd);
    cov_set_clr: cover property (@(posedge clk) disable iff (!nrst) outEv && outClr);
    cov_both: cover property (@(posedge clk) disable iff (!nrst) outIrq && inIrq);
endmodule

// ===== rtl/pmis_sticky_flag.sv
// sticky event flag, set wins over clear
`timescale 1ns/10ps
module pmis_sticky_flag
    import pmis_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // event and clear
    input wire logic setEv,
    input wire logic clrEv,
    // state
    output logic flag
);
    logic flag_r;

    // an event landing on the clear cycle must not be lost
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_r <= 1'b0;
        end else if (setEv) begin
            flag_r <= 1'b1;
        end else if (clrEv) begin
            flag_r <= 1'b0;
        end
    end

    assign flag = flag_r;
endmodule

// ===== verification/pmis_addon_model.sv
// add-on local bus model that fills incoming and drains outgoing mailboxes
`timescale 1ns/10ps
module pmis_addon_model
    import pmis_pkg::*;
(
    // clock
    input wire logic clk,
    // incoming mailbox writes
    output logic aoWrStb,
    output logic [1:0] aoWrMb,
    output logic [3:0] aoWrBe,
    output logic [31:0] aoWrData,
    // outgoing mailbox reads
    output logic aoRdStb,
    output logic [1:0] aoRdMb,
    output logic [3:0] aoRdBe,
    input wire logic [31:0] aoRdData
);
    initial begin
        aoWrStb = 1'b0;
        aoWrMb = 2'h0;
        aoWrBe = 4'h0;
        aoWrData = 32'h0;
        aoRdStb = 1'b0;
        aoRdMb = 2'h0;
        aoRdBe = 4'h0;
    end

    // released data is inverted so a stale word never looks valid
    task automatic wr(input logic [1:0] m, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        aoWrStb <= 1'b1;
        aoWrMb <= m;
        aoWrBe <= be;
        aoWrData <= d;
        @(posedge clk);
        aoWrStb <= 1'b0;
        aoWrData <= ~d;
    endtask

    task automatic rd(input logic [1:0] m, input logic [3:0] be, output logic [31:0] d);
        @(posedge clk);
        aoRdStb <= 1'b1;
        aoRdMb <= m;
        aoRdBe <= be;
        @(posedge clk);
        aoRdStb <= 1'b0;
        #1;
        d = aoRdData;
    endtask
endmodule

// ===== verification/pmis_mailbox_irq_tb.sv
// host side testbench of the pci mailbox interrupt block
`timescale 1ns/10ps
`include "pmis_defines.svh"
module pmis_mailbox_irq_tb
    import pmis_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [6:0] regAddr = 7'h00;
    logic [3:0] regBe = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata, aoRdData, aoWrData, v;
    logic regRdValid, intaN, aoWrStb, aoRdStb;
    logic [1:0] aoWrMb, aoRdMb;
    logic [3:0] aoWrBe, aoRdBe;
    int err_total = 0;
    int check_count = 0;

    always #2.5 clk = ~clk;

    pmis_mailbox_irq pmis_mailbox_irq_i (.clk(clk), .nrst(nrst), .regWr(regWr), .regRd(regRd),
        .regAddr(regAddr), .regBe(regBe), .regWdata(regWdata), .regRdata(regRdata),
        .regRdValid(regRdValid), .aoWrStb(aoWrStb), .aoWrMb(aoWrMb), .aoWrBe(aoWrBe),
        .aoWrData(aoWrData), .aoRdStb(aoRdStb), .aoRdMb(aoRdMb), .aoRdBe(aoRdBe),
        .aoRdData(aoRdData), .intaN(intaN));

    pmis_addon_model pmis_addon_model_i (.clk(clk), .aoWrStb(aoWrStb), .aoWrMb(aoWrMb),
        .aoWrBe(aoWrBe), .aoWrData(aoWrData), .aoRdStb(aoRdStb), .aoRdMb(aoRdMb),
        .aoRdBe(aoRdBe), .aoRdData(aoRdData));

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regBe <= be;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // read strobe is a single pulse; data is taken when the valid pulse shows
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        regBe <= 4'h1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        for (int i = 0; i < 4 && regRdValid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("regRdValid", {31'h0, regRdValid}, 32'h1);
        d = regRdata;
    endtask

    task automatic rdchk(input string n, input logic [6:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(n, d, exp);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rdchk("status", `PMIS_MAILBOX_EMPTY_FULL_STATUS_ADDR, 32'h0000ffff);
        rdchk("ctrl", `PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 32'h0);
        chk("intaN", {31'h0, intaN}, 32'h1);
        wr(`PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 4'h3, 32'h00001b16);
        pmis_addon_model_i.wr(2'h2, 4'hf, 32'h11223344);
        rdchk("ctrl", `PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 32'h00021b16);
        chk("intaN", {31'h0, intaN}, 32'h0);
        rdchk("status", `PMIS_MAILBOX_EMPTY_FULL_STATUS_ADDR, 32'h0f00ffff);
        rdchk("inbox", `PMIS_IMB_BASE + 7'h08, 32'h11223344);
        rdchk("status", `PMIS_MAILBOX_EMPTY_FULL_STATUS_ADDR, 32'h0e00ffff);
        wr(`PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 4'h4, 32'h0);
        rdchk("ctrl", `PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 32'h00021b16);
        wr(`PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 4'h4, 32'h00020000);
        rdchk("ctrl", `PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 32'h00001b16);
        chk("intaN", {31'h0, intaN}, 32'h1);
        wr(`PMIS_OMB_BASE + 7'h04, 4'hf, 32'hcafe0b0e);
        rdchk("outbox", `PMIS_OMB_BASE + 7'h04, 32'hcafe0b0e);
        pmis_addon_model_i.rd(2'h1, 4'h4, v);
        chk("addon data", v, 32'hcafe0b0e);
        rdchk("status", `PMIS_MAILBOX_EMPTY_FULL_STATUS_ADDR, 32'h0e00ff4f);
        rdchk("ctrl", `PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 32'h00011b16);
        chk("intaN", {31'h0, intaN}, 32'h0);
        wr(`PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 4'h4, 32'h00010000);
        rdchk("unmapped", 7'h40, 32'h0);
        // a write that misses the selected byte must not interrupt
        pmis_addon_model_i.wr(2'h2, 4'h7, 32'h55667788);
        rdchk("ctrl", `PMIS_PCI_INTERRUPT_CONTROL_STATUS_ADDR, 32'h00001b16);
        chk("intaN", {31'h0, intaN}, 32'h1);
        end_of_test();
    end
endmodule
